// file: design/bsta_defines.vh
// Shared constants of the boundary-scan test access block.
// Assumes inclusion by bare name from the design modules; holds definitions only.
`ifndef BSTA_DEFINES_VH
`define BSTA_DEFINES_VH

// Instruction register geometry and the fixed capture pattern
`define BSTA_IR_WIDTH 4
`define BSTA_IR_CAPTURE 4'h1

// Instruction codes (all ones is bypass, as usual for test ports)
`define BSTA_INS_EXTEST 4'h0
`define BSTA_INS_SAMPLE 4'h5
`define BSTA_INS_IDCODE 4'h6
`define BSTA_INS_BYPASS 4'hf

// Data register selector codes
`define BSTA_SEL_BYPASS 2'h0
`define BSTA_SEL_IDCODE 2'h1
`define BSTA_SEL_BSR 2'h2

// Width of one pin element and of the identification register
`define BSTA_CELL_BITS 3
`define BSTA_ID_WIDTH 32

// Position of each bit inside one pin element of the scan chain
`define BSTA_CELL_IN 0
`define BSTA_CELL_OE 1
`define BSTA_CELL_OUT 2

// Depth of the synchroniser on every pin input
`define BSTA_SYNC_STAGES 2

`endif

// file: design/bsta_buffer.v
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset; the reader may stall.
module bsta_buffer #(
    parameter WIDTH = 8
) (
    input wire i_clk_sys,
    input wire i_sys_rst,
    input wire [WIDTH-1:0] i_in_data,
    input wire i_in_valid,
    output wire o_in_ready,
    output reg [WIDTH-1:0] o_out_data,
    output wire o_out_valid,
    input wire i_out_ready
);
    reg [WIDTH-1:0] mem1;
    reg [1:0] count;
    wire push;
    wire pop;

    // Ready is honest: it falls only when both entries hold words
    assign o_in_ready = (count != 2'h2);
    assign o_out_valid = (count != 2'h0);
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;

    // Head word always sits in the output register; mem1 holds the second word
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            count <= 2'h0;
            mem1 <= {WIDTH{1'b0}};
            o_out_data <= {WIDTH{1'b0}};
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (count == 2'h0)
                        o_out_data <= i_in_data;
                    else
                        mem1 <= i_in_data;
                    count <= count + 2'h1;
                end
                2'b01: begin
                    o_out_data <= mem1;
                    count <= count - 2'h1;
                end
                2'b11: begin
                    // Count is one here, since push needs room and pop a word
                    o_out_data <= i_in_data;
                end
                default: count <= count;
            endcase
        end
    end
endmodule

// file: design/bsta_tap.v
// Boundary-scan test access port: TAP controller, instruction register,
// bypass, identification and boundary-scan data registers, and pin cells.
// Assumes the test pins come from outside and are sampled by i_clk_sys,
// which must run at least four times faster than the test clock.
//
// Behaviour
// - TDI is sampled at each detected rising edge of the test clock.
// - TDO changes only at detected falling edges of the test clock.
// - TDO is released (enable high) unless shifting instruction or data bits.
// - TMS is evaluated and the TAP state moves at each rising edge.
// - A low test reset resets the scan logic, without waiting for test clock edges.
// - Bypass register is exactly one bit between TDI and TDO.
// - Instruction register contents pick the operation and the selected data register.
// - All pin cells form one serial register selectable between TDI and TDO.
// - Without boundary cells, external-test and sample instructions select bypass.
// - Instruction register loads serially from TDI; its decode steers data registers.
// - Only TMS, TCK, TRST, system reset and port disable drive the controller; TDI/TDO form the path.
// - An identification register is selectable unless the variant omits it.
// - With the test option disabled, the four test pins serve as user I/O.
// - Cells force values onto pins and capture pin or core values serially.
// - Each pin takes a three-bit element: output, output enable, input.
// - Test-port pins themselves have no boundary cells.
`include "bsta_defines.vh"

module bsta_tap #(
    parameter NUM_PINS = 4,
    parameter HAS_BSR = 1,
    parameter HAS_IDCODE = 1,
    parameter [31:0] ID_VALUE = 32'h0a5a5001 // Arbitrary value, no real maker
) (
    input wire i_clk_sys,
    input wire i_sys_rst,
    input wire i_jtag_en,
    input wire i_tck,
    input wire i_tms,
    input wire i_tdi,
    input wire i_trst_n,
    output reg o_tdo,
    output reg o_tdo_oe_n,
    input wire i_user_tdo,
    input wire i_user_tdo_oe_n,
    output reg [2:0] o_user_pin_in,
    input wire [NUM_PINS-1:0] i_core_out,
    input wire [NUM_PINS-1:0] i_core_oe,
    output reg [NUM_PINS-1:0] o_core_in,
    output reg [NUM_PINS-1:0] o_pin_out,
    output reg [NUM_PINS-1:0] o_pin_oe_n,
    input wire [NUM_PINS-1:0] i_pin_in,
    output wire [NUM_PINS*`BSTA_CELL_BITS-1:0] o_upd_data,
    output wire o_upd_valid,
    input wire i_upd_ready
);
    localparam IRW = `BSTA_IR_WIDTH;
    localparam BSRW = NUM_PINS * `BSTA_CELL_BITS;
    localparam IDW = `BSTA_ID_WIDTH;

    // TAP states, binary coded
    localparam [3:0] ST_RESET = 4'h0;
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_SEL_DR = 4'h2;
    localparam [3:0] ST_CAP_DR = 4'h3;
    localparam [3:0] ST_SHIFT_DR = 4'h4;
    localparam [3:0] ST_EXIT1_DR = 4'h5;
    localparam [3:0] ST_PAUSE_DR = 4'h6;
    localparam [3:0] ST_EXIT2_DR = 4'h7;
    localparam [3:0] ST_UPD_DR = 4'h8;
    localparam [3:0] ST_SEL_IR = 4'h9;
    localparam [3:0] ST_CAP_IR = 4'ha;
    localparam [3:0] ST_SHIFT_IR = 4'hb;
    localparam [3:0] ST_EXIT1_IR = 4'hc;
    localparam [3:0] ST_PAUSE_IR = 4'hd;
    localparam [3:0] ST_EXIT2_IR = 4'he;
    localparam [3:0] ST_UPD_IR = 4'hf;

    // Next TAP state for a given TMS level
    function [3:0] tap_next;
        input [3:0] st;
        input tms;
        begin
            case (st)
                ST_RESET: tap_next = tms ? ST_RESET : ST_IDLE;
                ST_IDLE: tap_next = tms ? ST_SEL_DR : ST_IDLE;
                ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
                ST_CAP_DR: tap_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_SHIFT_DR: tap_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_EXIT1_DR: tap_next = tms ? ST_UPD_DR : ST_PAUSE_DR;
                ST_PAUSE_DR: tap_next = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
                ST_EXIT2_DR: tap_next = tms ? ST_UPD_DR : ST_SHIFT_DR;
                ST_UPD_DR: tap_next = tms ? ST_SEL_DR : ST_IDLE;
                ST_SEL_IR: tap_next = tms ? ST_RESET : ST_CAP_IR;
                ST_CAP_IR: tap_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_SHIFT_IR: tap_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_EXIT1_IR: tap_next = tms ? ST_UPD_IR : ST_PAUSE_IR;
                ST_PAUSE_IR: tap_next = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
                ST_EXIT2_IR: tap_next = tms ? ST_UPD_IR : ST_SHIFT_IR;
                ST_UPD_IR: tap_next = tms ? ST_SEL_DR : ST_IDLE;
                default: tap_next = ST_RESET;
            endcase
        end
    endfunction

    // Decode of the instruction into the selected data register
    function [1:0] dr_select;
        input [IRW-1:0] ins;
        begin
            case (ins)
                `BSTA_INS_EXTEST,
                `BSTA_INS_SAMPLE: dr_select = (HAS_BSR != 0) ?
                    `BSTA_SEL_BSR : `BSTA_SEL_BYPASS;
                `BSTA_INS_IDCODE: dr_select = (HAS_IDCODE != 0) ?
                    `BSTA_SEL_IDCODE : `BSTA_SEL_BYPASS;
                default: dr_select = `BSTA_SEL_BYPASS;
            endcase
        end
    endfunction

    // Instruction loaded at reset: identification if present, else bypass
    localparam [IRW-1:0] IR_RESET = (HAS_IDCODE != 0) ?
        `BSTA_INS_IDCODE : `BSTA_INS_BYPASS;

    // Synchronisers for every pin from outside the system clock domain
    reg tck_m;
    reg tck_s;
    reg tck_d;
    reg tms_m;
    reg tms_s;
    reg tdi_m;
    reg tdi_s;
    reg trst_m;
    reg trst_s;
    reg [NUM_PINS-1:0] pin_m;
    reg [NUM_PINS-1:0] pin_s;

    reg [3:0] state;
    reg [IRW-1:0] ir;
    reg [IRW-1:0] ir_sr;
    reg byp_sr;
    reg [IDW-1:0] id_sr;
    reg [BSRW-1:0] bsr_sr;
    reg [BSRW-1:0] bsr_upd;
    reg upd_pending;

    wire tck_rise;
    wire tck_fall;
    wire scan_rst;
    wire [1:0] dr_sel;
    wire extest_on;
    wire dr_tail;
    wire upd_in_ready;
    wire [BSRW-1:0] bsr_capture;

    // Two flip-flops before any logic looks at an outside level
    // Reset levels match the pins' rest levels, so no false test clock edge follows reset
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            tck_m <= 1'b0;
            tck_s <= 1'b0;
            tck_d <= 1'b0;
            tms_m <= 1'b1;
            tms_s <= 1'b1;
            tdi_m <= 1'b1;
            tdi_s <= 1'b1;
            trst_m <= 1'b0;
            trst_s <= 1'b0;
            pin_m <= {NUM_PINS{1'b0}};
            pin_s <= {NUM_PINS{1'b0}};
        end else begin
            tck_m <= i_tck;
            tck_s <= tck_m;
            tck_d <= tck_s;
            tms_m <= i_tms;
            tms_s <= tms_m;
            tdi_m <= i_tdi;
            tdi_s <= tdi_m;
            trst_m <= i_trst_n;
            trst_s <= trst_m;
            pin_m <= i_pin_in;
            pin_s <= pin_m;
        end
    end

    // Test clock edges found from the synchronised level
    assign tck_rise = tck_s & ~tck_d;
    assign tck_fall = ~tck_s & tck_d;

    // Scan reset needs no test clock edge; a disabled port also sits in reset
    // The test reset is synchronised, so it takes hold two system clocks late
    assign scan_rst = i_sys_rst | ~trst_s | ~i_jtag_en;

    assign dr_sel = dr_select(ir);
    assign extest_on = (ir == `BSTA_INS_EXTEST) && (HAS_BSR != 0);

    // Capture image: output, enable and pin input per element; test pins excluded
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g = g + 1) begin : gen_cell
            assign bsr_capture[g*`BSTA_CELL_BITS+`BSTA_CELL_OUT] = i_core_out[g];
            assign bsr_capture[g*`BSTA_CELL_BITS+`BSTA_CELL_OE] = i_core_oe[g];
            assign bsr_capture[g*`BSTA_CELL_BITS+`BSTA_CELL_IN] = pin_s[g];
        end
    endgenerate

    // Serial bit that leaves the selected data register
    assign dr_tail = (dr_sel == `BSTA_SEL_BSR) ? bsr_sr[0] :
                     (dr_sel == `BSTA_SEL_IDCODE) ? id_sr[0] : byp_sr;

    // TAP controller: only TMS, the test clock and scan reset (test reset, system reset, port off) move it
    always @(posedge i_clk_sys) begin
        if (scan_rst) begin
            state <= ST_RESET;
        end else if (tck_rise) begin
            state <= tap_next(state, tms_s);
        end
    end

    // Instruction register: capture, shift from TDI, update on the falling edge
    always @(posedge i_clk_sys) begin
        if (scan_rst) begin
            ir_sr <= {IRW{1'b0}};
            ir <= IR_RESET;
        end else if (state == ST_RESET) begin
            ir <= IR_RESET;
        end else if (tck_rise && state == ST_CAP_IR) begin
            ir_sr <= `BSTA_IR_CAPTURE;
        end else if (tck_rise && state == ST_SHIFT_IR) begin
            ir_sr <= {tdi_s, ir_sr[IRW-1:1]};
        end else if (tck_fall && state == ST_UPD_IR) begin
            ir <= ir_sr;
        end
    end

    // Bypass and identification registers
    always @(posedge i_clk_sys) begin
        if (scan_rst) begin
            byp_sr <= 1'b0;
            id_sr <= {IDW{1'b0}};
        end else if (tck_rise && state == ST_CAP_DR) begin
            byp_sr <= 1'b0;
            id_sr <= ID_VALUE;
        end else if (tck_rise && state == ST_SHIFT_DR) begin
            if (dr_sel == `BSTA_SEL_BYPASS)
                byp_sr <= tdi_s;
            if (dr_sel == `BSTA_SEL_IDCODE)
                id_sr <= {tdi_s, id_sr[IDW-1:1]};
        end
    end

    // Boundary-scan chain: one serial register through all pin elements
    always @(posedge i_clk_sys) begin
        if (scan_rst) begin
            bsr_sr <= {BSRW{1'b0}};
            bsr_upd <= {BSRW{1'b0}};
        end else if (dr_sel == `BSTA_SEL_BSR) begin
            if (tck_rise && state == ST_CAP_DR)
                bsr_sr <= bsr_capture;
            else if (tck_rise && state == ST_SHIFT_DR)
                bsr_sr <= {tdi_s, bsr_sr[BSRW-1:1]};
            else if (tck_fall && state == ST_UPD_DR)
                bsr_upd <= bsr_sr;
        end
    end

    // Serial output: changes on the falling edge, released outside shift states
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_tdo <= 1'b0;
            o_tdo_oe_n <= 1'b1;
        end else if (!i_jtag_en) begin
            o_tdo <= i_user_tdo;
            o_tdo_oe_n <= i_user_tdo_oe_n;
        end else if (scan_rst || state == ST_RESET) begin
            // Also covers the first cycles after user I/O mode, which left the
            // enable where the user had it; reset never shifts, so release is safe
            o_tdo_oe_n <= 1'b1;
        end else if (tck_fall) begin
            if (state == ST_SHIFT_IR) begin
                o_tdo <= ir_sr[0];
                o_tdo_oe_n <= 1'b0;
            end else if (state == ST_SHIFT_DR) begin
                o_tdo <= dr_tail;
                o_tdo_oe_n <= 1'b0;
            end else begin
                o_tdo_oe_n <= 1'b1;
            end
        end
    end

    // Pin and core paths; external test forces the updated values onto pins
    // Pin inputs reach the core only through the synchroniser, never raw
    integer k;
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_pin_out <= {NUM_PINS{1'b0}};
            o_pin_oe_n <= {NUM_PINS{1'b1}};
            o_core_in <= {NUM_PINS{1'b0}};
        end else begin
            for (k = 0; k < NUM_PINS; k = k + 1) begin
                if (extest_on) begin
                    o_pin_out[k] <= bsr_upd[k*`BSTA_CELL_BITS+`BSTA_CELL_OUT];
                    o_pin_oe_n[k] <= ~bsr_upd[k*`BSTA_CELL_BITS+`BSTA_CELL_OE];
                end else begin
                    o_pin_out[k] <= i_core_out[k];
                    o_pin_oe_n[k] <= ~i_core_oe[k];
                end
                o_core_in[k] <= pin_s[k];
            end
        end
    end

    // Test pin levels handed to the core when the port is user I/O
    always @(posedge i_clk_sys) begin
        if (i_sys_rst || i_jtag_en)
            o_user_pin_in <= 3'h0;
        else
            o_user_pin_in <= {tck_s, tms_s, tdi_s};
    end

    // Each boundary update is offered to the core; a stall keeps it pending.
    // The drain follows the buffer's ready, so a full buffer simply holds the flag.
    // A second update before the first drains replaces the pending word.
    always @(posedge i_clk_sys) begin
        if (scan_rst)
            upd_pending <= 1'b0;
        else if (tck_fall && state == ST_UPD_DR && dr_sel == `BSTA_SEL_BSR)
            upd_pending <= 1'b1;
        else if (upd_in_ready)
            upd_pending <= 1'b0;
    end

    // Two entries let the core stall across one update without losing a word
    bsta_buffer #(
        .WIDTH(BSRW)
    ) u_upd_buf (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_in_data(bsr_upd),
        .i_in_valid(upd_pending),
        .o_in_ready(upd_in_ready),
        .o_out_data(o_upd_data),
        .o_out_valid(o_upd_valid),
        .i_out_ready(i_upd_ready)
    );
endmodule

// file: dv/bsta_tap_monitor.sv
// Checker for the test access block, bound to its top module.
// Assumes a test clock under a quarter of i_clk_sys; sees top-level ports only.
module bsta_tap_mon #(
    parameter NUM_PINS = 4
) (
    input wire i_clk_sys,
    input wire i_sys_rst,
    input wire i_jtag_en,
    input wire i_tck,
    input wire i_trst_n,
    input wire o_tdo,
    input wire o_tdo_oe_n,
    input wire i_user_tdo,
    input wire i_user_tdo_oe_n,
    input wire [2:0] o_user_pin_in,
    input wire [NUM_PINS-1:0] i_core_out,
    input wire [NUM_PINS-1:0] i_core_oe,
    input wire [NUM_PINS-1:0] o_core_in,
    input wire [NUM_PINS-1:0] o_pin_out,
    input wire [NUM_PINS-1:0] o_pin_oe_n,
    input wire [NUM_PINS-1:0] i_pin_in,
    input wire [NUM_PINS*3-1:0] o_upd_data,
    input wire o_upd_valid,
    input wire i_upd_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    // Port on and test reset high; then TDO may move only at test clock falls
    wire quiet = i_jtag_en && i_trst_n;
    // Test reset held long enough to pass the synchroniser
    sequence s_trst_held;
        (!i_trst_n && i_jtag_en) [*6];
    endsequence
    // Port switched off, test pins become user I/O
    sequence s_user_mode;
        !i_jtag_en [*4];
    endsequence
    tdo_fall_edge_a: assert property ($changed(o_tdo) && quiet && $past(quiet, 5) |->
        !$past(i_tck, 2)) else $error("tdo moved away from a test clock fall");
    oe_fall_edge_a: assert property ($changed(o_tdo_oe_n) && quiet && $past(quiet, 5) |->
        !$past(i_tck, 2)) else $error("tdo enable moved away from a test clock fall");
    trst_release_a: assert property (s_trst_held |=> o_tdo_oe_n)
        else $error("tdo driven during test reset");
    pins_core_a: assert property (s_trst_held |=> o_pin_out == $past(i_core_out) &&
        o_pin_oe_n == ~$past(i_core_oe)) else $error("pins not following core in reset");
    user_tdo_a: assert property (s_user_mode |-> o_tdo == $past(i_user_tdo) &&
        o_tdo_oe_n == $past(i_user_tdo_oe_n)) else $error("tdo pin not user driven");
    user_pins_a: assert property (i_jtag_en [*3] |-> o_user_pin_in == 3'h0)
        else $error("test pins leak to core while port on");
    core_in_a: assert property ($stable(i_pin_in) [*6] |-> o_core_in == i_pin_in)
        else $error("core input not the synced pin");
    upd_hold_a: assert property (o_upd_valid && !i_upd_ready |=> o_upd_valid &&
        $stable(o_upd_data)) else $error("update word dropped while stalled");
endmodule

bind bsta_tap bsta_tap_mon #(.NUM_PINS(NUM_PINS)) u_mon (.i_clk_sys, .i_sys_rst, .i_jtag_en,
    .i_tck, .i_trst_n, .o_tdo, .o_tdo_oe_n, .i_user_tdo, .i_user_tdo_oe_n, .o_user_pin_in,
    .i_core_out, .i_core_oe, .o_core_in, .o_pin_out, .o_pin_oe_n, .i_pin_in, .o_upd_data,
    .o_upd_valid, .i_upd_ready);

// file: dv/bsta_host.sv
// Behavioural test-port host driving test clock, mode select, data in and reset.
// Assumes the bench clock; a test clock half period is four system cycles.
module bsta_host (
    input wire i_clk_sys,
    input wire i_tdo,
    input wire i_tdo_oe_n,
    output logic o_tck = 0,
    output logic o_tms = 1,
    output logic o_tdi = 0,
    output logic o_trst_n = 0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic driven;
    logic nc;
    // Clock stands still between calls; changes land just after a system edge
    task half;
        repeat (4) @(posedge i_clk_sys);
        #1;
    endtask
    // Test reset is driven to the level given and held there until the next call
    task set_trst(input logic v);
        o_trst_n = v;
    endtask
    // Static levels on mode select and data in, read by the core in user I/O mode
    task set_pins(input logic tms, input logic tdi);
        o_tms = tms;
        o_tdi = tdi;
    endtask
    // Mode and data set at the fall and held over the rise; TDO taken at the rise
    task tick(input logic tms, input logic tdi, output logic tdo);
        o_tms = tms;
        o_tdi = tdi;
        half();
        tdo = i_tdo;
        o_tck = 1;
        half();
        o_tck = 0;
    endtask
    // Five ones reach reset from any state, then settle in idle
    task go_idle;
        repeat (5) tick(1, 0, nc);
        tick(0, 0, nc);
    endtask
    // Whole scan from idle back to idle, LSB first, noting whether TDO stayed driven
    task scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
        dout = 64'h0;
        driven = 1;
        tick(1, 0, nc);
        if (ir) tick(1, 0, nc);
        tick(0, 0, nc);
        tick(0, 0, nc);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], dout[i]);
            driven = driven & ~i_tdo_oe_n;
        end
        tick(1, 0, nc);
        tick(0, 0, nc);
    endtask
endmodule

// file: dv/test_bsta_tap.sv
// Self-checking bench for the test access block with a behavioural host.
// Assumes four pins and the default instruction codes of the block.
module test_bsta_tap;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] ID = 32'h3c5a0e71; // Arbitrary value
    logic i_clk_sys = 0, i_sys_rst = 1, i_jtag_en = 1, i_user_tdo = 0;
    logic i_user_tdo_oe_n = 1, i_upd_ready = 0;
    logic [3:0] i_core_out = 4'h0, i_core_oe = 4'h0, i_pin_in = 4'h0;
    wire i_tck, i_tms, i_tdi, i_trst_n, o_tdo, o_tdo_oe_n, o_upd_valid;
    wire [2:0] o_user_pin_in;
    wire [3:0] o_core_in, o_pin_out, o_pin_oe_n;
    wire [11:0] o_upd_data;
    logic [63:0] got;
    logic d;
    int errors = 0, cmp_count = 0, cycles = 0;
    always #12.5 i_clk_sys = ~i_clk_sys;
    bsta_tap #(.ID_VALUE(ID)) uut (.i_clk_sys, .i_sys_rst, .i_jtag_en, .i_tck, .i_tms, .i_tdi,
        .i_trst_n, .o_tdo, .o_tdo_oe_n, .i_user_tdo, .i_user_tdo_oe_n, .o_user_pin_in,
        .i_core_out, .i_core_oe, .o_core_in, .o_pin_out, .o_pin_oe_n, .i_pin_in,
        .o_upd_data, .o_upd_valid, .i_upd_ready);
    bsta_host host (.i_clk_sys, .i_tdo(o_tdo), .i_tdo_oe_n(o_tdo_oe_n), .o_tck(i_tck),
        .o_tms(i_tms), .o_tdi(i_tdi), .o_trst_n(i_trst_n));
    wire l_tdo, l_tdo_oe_n, l_upd_valid;
    wire [2:0] l_user_pin_in;
    wire [3:0] l_core_in, l_pin_out, l_pin_oe_n;
    wire [11:0] l_upd_data;
    // Variant without cells or identification, on the same test pins
    bsta_tap #(.HAS_BSR(0), .HAS_IDCODE(0)) uut_lite (.i_clk_sys, .i_sys_rst, .i_jtag_en, .i_tck,
        .i_tms, .i_tdi, .i_trst_n, .o_tdo(l_tdo), .o_tdo_oe_n(l_tdo_oe_n), .i_user_tdo,
        .i_user_tdo_oe_n, .o_user_pin_in(l_user_pin_in), .i_core_out, .i_core_oe,
        .o_core_in(l_core_in), .o_pin_out(l_pin_out), .o_pin_oe_n(l_pin_oe_n), .i_pin_in,
        .o_upd_data(l_upd_data), .o_upd_valid(l_upd_valid), .i_upd_ready);
    task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task wait_cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    // Expected pin drive {oe_n, out} from an update word
    function automatic logic [7:0] pins(input logic [11:0] w);
        for (int i = 0; i < 4; i++) begin
            pins[i] = w[3*i+2];
            pins[4+i] = ~w[3*i+1];
        end
    endfunction
    // Capture pattern, then a test reset in mid-shift with the clock standing still
    task t_idcode;
        host.set_trst(1);
        host.go_idle();
        host.scan(1, 4, 64'hf, got);
        check("ir capture", got, 64'h1);
        check("tdo driven in shift", host.driven, 64'h1);
        host.tick(1, 0, d);
        host.tick(0, 0, d);
        host.tick(0, 0, d);
        wait_cyc(6);
        check("tdo driven in shift dr", o_tdo_oe_n, 64'h0);
        host.set_trst(0);
        wait_cyc(8);
        check("tdo released in reset", o_tdo_oe_n, 64'h1);
        host.set_trst(1);
        host.tick(0, 0, d);
        host.scan(0, 32, 64'h0, got);
        check("id register", got, ID);
        $display("test idcode done");
    endtask
    // Bypass and an unlisted code both give a one-bit path
    task t_bypass;
        logic [3:0] codes [2];
        codes = '{4'hf, 4'h3};
        foreach (codes[k]) begin
            host.scan(1, 4, {60'h0, codes[k]}, got);
            host.scan(0, 8, 64'hb4, got);
            check("bypass path", got, 64'h68);
        end
        $display("test bypass done");
    endtask
    // Sample, preload, external drive, then drain three stalled update words
    task t_scan;
        logic [11:0] exp;
        logic [11:0] w [3];
        w = '{12'h5c3, 12'h0a6, 12'hf19};
        i_core_out = 4'ha;
        i_core_oe = 4'h6;
        i_pin_in = 4'h9;
        for (int i = 0; i < 4; i++) exp[3*i+:3] = {i_core_out[i], i_core_oe[i], i_pin_in[i]};
        host.scan(1, 4, 64'h5, got);
        host.scan(0, 12, {52'h0, w[0]}, got);
        check("captured cells", got, {52'h0, exp});
        host.scan(1, 4, 64'h0, got);
        host.scan(0, 12, {52'h0, w[1]}, got);
        host.scan(0, 12, {52'h0, w[2]}, got);
        check("pins from cells", {o_pin_oe_n, o_pin_out}, pins(w[2]));
        check("lite pins from core", {l_pin_oe_n, l_pin_out}, 64'h9a);
        check("lite no update", l_upd_valid, 64'h0);
        foreach (w[k]) begin
            check("update valid", o_upd_valid, 64'h1);
            check("update word", o_upd_data, w[k]);
            i_upd_ready = 1;
            wait_cyc(1);
            i_upd_ready = 0;
            wait_cyc(2);
        end
        check("buffer empty", o_upd_valid, 64'h0);
        host.go_idle();
        check("pins from core", {o_pin_oe_n, o_pin_out}, {~i_core_oe, i_core_out});
        $display("test scan done");
    endtask
    // Port switched off: test pins serve the core and the user drives TDO
    task t_user;
        i_jtag_en = 0;
        i_user_tdo = 1;
        i_user_tdo_oe_n = 0;
        host.set_pins(1, 1);
        wait_cyc(6);
        check("user tdo", {o_tdo_oe_n, o_tdo}, 64'h1);
        check("user test pins", o_user_pin_in, 64'h3);
        i_jtag_en = 1;
        i_user_tdo_oe_n = 1;
        wait_cyc(6);
        check("tdo released", o_tdo_oe_n, 64'h1);
        check("test pins hidden", o_user_pin_in, 64'h0);
        $display("test user done");
    endtask
    // Ceiling well above the roughly 1500 cycles the tests need
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            report_and_stop();
        end
    end
    // Main sequence
    initial begin
        wait_cyc(2);
        i_sys_rst = 0;
        t_idcode();
        t_bypass();
        t_scan();
        t_user();
        report_and_stop();
    end
endmodule
